// ---- common/opms_pkg.sv ----
// constants, carriers and states of the off-line pwm mode sequencer
//------------------------------------------------------------------
// Behaviour
// RQ1 - demag status drops on zero crossing, held until the next pulse.
// RQ2 - gate stays off for the whole demagnetization phase.
// RQ3 - demag current above 120 uA latches the gate off (quick overvoltage).
// RQ4 - grounded demag pin disables demag detection and quick overvoltage.
// RQ5 - ramp charges to the 4 V level, discharges to the 2.4 V level.
// RQ6 - ramp waits at valley until demag completes, giving self oscillation.
// RQ7 - clock is the ramp discharge; on-time ends when ramp meets control.
// RQ8 - supply above 15.4 V trips the fixed overvoltage protection.
// RQ9 - any overvoltage trip keeps the gate off until start-up completes.
// RQ10 - start-up enables 9 mA source; at 13 V it stops, switching begins.
// RQ11 - each on-time end stores 1 without overcurrent, 0 with overcurrent.
// RQ12 - supply falling to 10 V ends switching, enters latched-off phase.
// RQ13 - supply falling to 6.5 V ends latched-off, restarts start-up.
// RQ14 - latched-off sets mode if last work clean, else resets; kept in start-up.
// RQ15 - mode 0 gives normal switching: sense source off, 1 V limit.
// RQ16 - mode 1 asserts stand-by and enables the sense current source.
// RQ17 - on-time limited to 80 percent of the cycle.
// RQ18 - demag current above 24 uA resets mode, restoring normal mode; the code checks it only in the start-up phase.
// RQ19 - pulse latch set per cycle, reset by pwm or overcurrent trip.
// RQ20 - gate low in start-up, latched-off and while a protection holds.
// RQ21 - all comparator inputs pass two flip-flops before use.
//------------------------------------------------------------------
`default_nettype none

package opms_pkg;

  //----------------------------------------------------------------
  // register map, byte addresses
  //----------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_PULSES    = 4'h8;
  localparam logic [3:0]  REG_PERIOD    = 4'hC;
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_CLR_BIT  = 1;
  localparam logic        CTRL_RUN_RST  = 1'b1;

  //----------------------------------------------------------------
  // analog thresholds, millivolts, carried by the comparators
  //----------------------------------------------------------------
  localparam int MV_ZERO_CROSS = 50;
  localparam int MV_RAMP_LOW   = 2400;
  localparam int MV_RAMP_HIGH  = 4000;
  localparam int MV_VCC_OVP    = 15400;
  localparam int MV_VCC_START  = 13000;
  localparam int MV_VCC_STOP   = 10000;
  localparam int MV_VCC_RESET  = 6500;

  //----------------------------------------------------------------
  // duty limit as a fraction, 80 percent
  //----------------------------------------------------------------
  localparam int DUTY_NUM = 4;
  localparam int DUTY_DEN = 5;

  //----------------------------------------------------------------
  // comparator bundle from the analog front end
  //----------------------------------------------------------------
  typedef struct packed {
    logic zeroCross;      // aux winding below 50 mV
    logic demagGrounded;  // demag pin held at ground
    logic demagAbove24;   // demag current above 24 uA
    logic demagAbove120;  // demag current above 120 uA
    logic vccAbove15v4;   // supply above fixed ovp level
    logic vccAt13;        // supply reached start level
    logic vccAt10;        // supply fell to stop level
    logic vccAt6v5;       // supply fell to restart level
    logic rampAtUpper;    // ramp at 4 V
    logic rampAtLower;    // ramp at 2.4 V
    logic pwmTrip;        // ramp reached control voltage
    logic ocTrip;         // current sense above limit
  } opms_cmp_t;

  localparam int CMP_W = $bits(opms_cmp_t);

  typedef enum logic [1:0] {
    PH_STARTUP,
    PH_SWITCHING,
    PH_LATCHED
  } opms_phase_t;

  //----------------------------------------------------------------
  // status word layout, high bits first
  //----------------------------------------------------------------
  typedef struct packed {
    logic [21:0] reserved;
    logic        standby;
    logic        rampCharge;
    logic        gate;
    logic        demagStatus;
    logic        quickOvp;
    logic        fixedOvp;
    logic        lastWork;
    logic        mode;
    logic [1:0]  phase;
  } opms_status_t;

endpackage : opms_pkg

`default_nettype wire

// ---- core/opms_sync.sv ----
// two-stage synchronizer for the comparator vector
`default_nettype none

module opms_sync
  import opms_pkg::*;
#(
  parameter int WIDTH = CMP_W
)(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async,
  output var  logic [WIDTH-1:0] synced
);

  //----------------------------------------------------------------
  // one pair of flops per bit
  //----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic stable_q;
      // first stage feeds only the second
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end
        else
        begin
          meta_q   <= async[i]; // RQ21
          stable_q <= meta_q;   // RQ21
        end
      end
      assign synced[i] = stable_q;
    end
  endgenerate

endmodule : opms_sync

`default_nettype wire

// ---- core/opms_core.sv ----
// pulse gating, protection latches and phase sequencer with avalon registers
`default_nettype none

module opms_core
  import opms_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // analog comparator outputs
  input  wire opms_cmp_t         cmpIn,
  // drives toward the power stage
  output var  logic              gateDrive,
  output var  logic              hvSourceEn,
  output var  logic              csSourceEn,
  output var  logic              standbyMode,
  output var  logic              rampCharge,
  output var  logic              demagComplete,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest
);

  //----------------------------------------------------------------
  // comparator synchronization
  //----------------------------------------------------------------
  logic [CMP_W-1:0] cmpSync;
  opms_cmp_t        s;

  opms_sync #(
    .WIDTH (CMP_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .async   (cmpIn),
    .synced  (cmpSync)
  );

  assign s = opms_cmp_t'(cmpSync);

  //----------------------------------------------------------------
  // state of the pulse and phase logic
  //----------------------------------------------------------------
  opms_phase_t      phase_q,     phase_d;
  logic             mode_q,      mode_d;
  logic             lastWork_q,  lastWork_d;
  logic             fixedOvp_q,  fixedOvp_d;
  logic             quickOvp_q,  quickOvp_d;
  logic             demag_q,     demag_d;
  logic             ramp_q,      ramp_d;
  logic             pulse_q,     pulse_d;
  logic [CNT_W-1:0] onCnt_q,     onCnt_d;
  logic [CNT_W-1:0] chargeCnt_q, chargeCnt_d;
  logic [CNT_W-1:0] period_q,    period_d;
  logic [CNT_W-1:0] pulseCnt_q,  pulseCnt_d;

  // register-side state
  logic             run_q,       run_d;
  logic             ack_q,       ack_d;
  logic [31:0]      rdData_q,    rdData_d;

  logic             demagInhibit;
  logic             demagDone;
  logic             switchOk;
  logic             cycleStart;
  logic             startDone;
  logic             pulseEnd;
  logic             clrPulses;
  logic             busReq;
  logic             busTake;
  logic [CNT_W+2:0] limitWide;
  logic [CNT_W-1:0] onLimit;
  opms_status_t     status;

  //----------------------------------------------------------------
  // derived conditions
  //----------------------------------------------------------------
  // grounded pin turns off demag sensing
  assign demagInhibit = s.demagGrounded;                        // RQ4
  assign demagDone    = ~demag_q;
  // switching permitted only in a healthy switching phase
  assign switchOk     = (phase_q == PH_SWITCHING) & ~fixedOvp_q
                        & ~quickOvp_q & run_q;                  // RQ20
  // cycle starts when the ramp leaves the valley
  assign cycleStart   = ~ramp_q & s.rampAtLower & demagDone;    // RQ6
  assign startDone    = (phase_q == PH_STARTUP) & s.vccAt13;
  // on-time ceiling from the last measured charge time
  assign limitWide    = ({3'h0, period_q} * (CNT_W+3)'(DUTY_NUM))
                        / (CNT_W+3)'(DUTY_DEN);                 // RQ17
  assign onLimit      = limitWide[CNT_W-1:0];

  //----------------------------------------------------------------
  // oscillator control
  //----------------------------------------------------------------
  always_comb
  begin
    ramp_d      = ramp_q;
    chargeCnt_d = chargeCnt_q;
    period_d    = period_q;
    if (ramp_q)
    begin
      chargeCnt_d = chargeCnt_q + 1'b1;
      if (s.rampAtUpper)
      begin
        ramp_d      = 1'b0;                                     // RQ5
        period_d    = chargeCnt_q;
        chargeCnt_d = '0;
      end
    end
    else if (cycleStart)
    begin
      ramp_d = 1'b1;                                            // RQ5
    end
  end

  //----------------------------------------------------------------
  // pulse latch and on-time counter
  //----------------------------------------------------------------
  always_comb
  begin
    pulse_d = pulse_q;
    onCnt_d = onCnt_q;
    if (cycleStart && switchOk)
    begin
      pulse_d = 1'b1;                                           // RQ19
      onCnt_d = '0;
    end
    else if (pulse_q)
    begin
      onCnt_d = onCnt_q + 1'b1;
      // pwm, overcurrent, duty ceiling, clock or protection ends it
      if (s.pwmTrip || s.ocTrip || !switchOk || !ramp_q
          || (onCnt_q >= onLimit))
      begin
        pulse_d = 1'b0;                                         // RQ7
      end
    end
  end

  assign pulseEnd = pulse_q & ~pulse_d;

  //----------------------------------------------------------------
  // last work status and demag latch
  //----------------------------------------------------------------
  always_comb
  begin
    lastWork_d = lastWork_q;
    demag_d    = demag_q;
    if (pulseEnd)
    begin
      lastWork_d = ~s.ocTrip;                                   // RQ11
    end
    if (demagInhibit)
    begin
      demag_d = 1'b0;                                           // RQ4
    end
    else if (pulseEnd)
    begin
      demag_d = 1'b1;                                           // RQ2
    end
    else if (demag_q && s.zeroCross)
    begin
      demag_d = 1'b0;                                           // RQ1
    end
  end

  //----------------------------------------------------------------
  // overvoltage latches, trip wins over the start-up clear
  //----------------------------------------------------------------
  always_comb
  begin
    fixedOvp_d = fixedOvp_q | s.vccAbove15v4;                   // RQ8
    quickOvp_d = quickOvp_q | (s.demagAbove120 & ~demagInhibit); // RQ3
    if (startDone)
    begin
      fixedOvp_d = s.vccAbove15v4;                              // RQ9
      quickOvp_d = s.demagAbove120 & ~demagInhibit;             // RQ9
    end
  end

  //----------------------------------------------------------------
  // phase sequencer and mode latch
  //----------------------------------------------------------------
  always_comb
  begin
    phase_d = phase_q;
    mode_d  = mode_q;
    case (phase_q)
      PH_STARTUP:
      begin
        if (s.demagAbove24)
        begin
          mode_d = 1'b0;                                        // RQ18
        end
        if (s.vccAt13)
        begin
          phase_d = PH_SWITCHING;                               // RQ10
        end
      end
      PH_SWITCHING:
      begin
        if (s.vccAt10)
        begin
          phase_d = PH_LATCHED;                                 // RQ12
        end
      end
      PH_LATCHED:
      begin
        mode_d = lastWork_q;                                    // RQ14
        if (s.vccAt6v5)
        begin
          phase_d = PH_STARTUP;                                 // RQ13
        end
      end
      default:
      begin
        phase_d = PH_STARTUP;
      end
    endcase
  end

  //----------------------------------------------------------------
  // pulse counter
  //----------------------------------------------------------------
  always_comb
  begin
    pulseCnt_d = pulseCnt_q;
    if (clrPulses)
    begin
      pulseCnt_d = '0;
    end
    if (pulseEnd)
    begin
      pulseCnt_d = clrPulses ? CNT_W'(1) : pulseCnt_q + 1'b1;
    end
  end

  //----------------------------------------------------------------
  // core registers
  //----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      phase_q     <= PH_STARTUP;
      mode_q      <= 1'b0;
      lastWork_q  <= 1'b0;
      fixedOvp_q  <= 1'b0;
      quickOvp_q  <= 1'b0;
      demag_q     <= 1'b0;
      ramp_q      <= 1'b0;
      pulse_q     <= 1'b0;
      onCnt_q     <= '0;
      chargeCnt_q <= '0;
      period_q    <= '1;
      pulseCnt_q  <= '0;
    end
    else
    begin
      phase_q     <= phase_d;
      mode_q      <= mode_d;
      lastWork_q  <= lastWork_d;
      fixedOvp_q  <= fixedOvp_d;
      quickOvp_q  <= quickOvp_d;
      demag_q     <= demag_d;
      ramp_q      <= ramp_d;
      pulse_q     <= pulse_d;
      onCnt_q     <= onCnt_d;
      chargeCnt_q <= chargeCnt_d;
      period_q    <= period_d;
      pulseCnt_q  <= pulseCnt_d;
    end
  end

  //----------------------------------------------------------------
  // outputs toward the power stage
  //----------------------------------------------------------------
  assign gateDrive     = pulse_q & demagDone;                   // RQ2
  assign hvSourceEn    = (phase_q == PH_STARTUP);               // RQ10
  assign standbyMode   = mode_q & (phase_q == PH_SWITCHING);    // RQ16
  // sense source in start-up and in pulsed switching only
  assign csSourceEn    = standbyMode | (phase_q == PH_STARTUP); // RQ15
  assign rampCharge    = ramp_q;
  assign demagComplete = demagDone;

  //----------------------------------------------------------------
  // status word
  //----------------------------------------------------------------
  always_comb
  begin
    status             = '0;
    status.phase       = phase_q;
    status.mode        = mode_q;
    status.lastWork    = lastWork_q;
    status.fixedOvp    = fixedOvp_q;
    status.quickOvp    = quickOvp_q;
    status.demagStatus = demag_q;
    status.gate        = pulse_q;
    status.rampCharge  = ramp_q;
    status.standby     = standbyMode;
  end

  //----------------------------------------------------------------
  // avalon slave: one wait state on every access
  //----------------------------------------------------------------
  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_q;
  assign busTake         = busReq & ack_q;
  assign clrPulses       = busTake & avs_write & (avs_address == REG_CTRL)
                           & avs_byteenable[0] & avs_writedata[CTRL_CLR_BIT];
  assign avs_readdata    = rdData_q;

  // read mux and control write
  always_comb
  begin
    ack_d    = busReq & ~ack_q;
    run_d    = run_q;
    rdData_d = rdData_q;
    if (ack_d && avs_read)
    begin
      case (avs_address)
        REG_CTRL:   rdData_d = {31'h0, run_q};
        REG_STATUS: rdData_d = status;
        REG_PULSES: rdData_d = {{(32-CNT_W){1'b0}}, pulseCnt_q};
        REG_PERIOD: rdData_d = {{(32-CNT_W){1'b0}}, period_q};
        default:    rdData_d = 32'h0;
      endcase
    end
    if (busTake && avs_write && (avs_address == REG_CTRL)
        && avs_byteenable[0])
    begin
      run_d = avs_writedata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ack_q    <= 1'b0;
      run_q    <= CTRL_RUN_RST;
      rdData_q <= 32'h0;
    end
    else
    begin
      ack_q    <= ack_d;
      run_q    <= run_d;
      rdData_q <= rdData_d;
    end
  end

endmodule : opms_core

`default_nettype wire

// ---- sim/opms_front.sv ----
// far-side model: timing ramp, current sense and aux winding comparators
`default_nettype none

module opms_front
  import opms_pkg::*;
#(
  parameter int RTOP = 20
)(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       gateDrive,
  input  wire logic       rampCharge,
  input  wire opms_cmp_t  knob,
  input  wire logic       ocEn,
  input  wire logic [7:0] ctrlLvl,
  input  wire logic [7:0] dmgLen,
  output var  opms_cmp_t  cmp
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ramp_q;
  logic [7:0] ramp_d;
  logic [7:0] offCnt_q;
  logic [7:0] offCnt_d;

  // ramp climbs a step a cycle, falls to the valley at once; off time counted
  always_comb
  begin
    ramp_d   = rampCharge ? ((ramp_q < 8'(RTOP)) ? ramp_q + 8'h01 : ramp_q) : 8'h00;
    offCnt_d = gateDrive ? 8'h00 : ((offCnt_q == 8'hFF) ? offCnt_q : offCnt_q + 8'h01);
  end

  // state registers
  always_ff @(posedge sys_clk)
  begin
    ramp_q   <= reset ? 8'h00 : ramp_d;
    offCnt_q <= reset ? 8'h00 : offCnt_d;
  end

  // comparator levels; supply and demag current levels come from the bench
  always_comb
  begin
    cmp             = knob;
    cmp.rampAtUpper = (ramp_q >= 8'(RTOP));
    cmp.rampAtLower = (ramp_q == 8'h00);
    cmp.pwmTrip     = (ramp_q >= ctrlLvl);
    cmp.ocTrip      = ocEn && gateDrive && (ramp_q >= 8'h03);
    cmp.zeroCross   = (offCnt_q >= dmgLen); // winding rings out after dmgLen
  end
endmodule : opms_front

`default_nettype wire

// ---- sim/opms_core_sva.sv ----
// concurrent checks on the sequencer ports
`default_nettype none

module opms_core_sva
  import opms_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      reset,
  input wire opms_cmp_t cmpIn,
  input wire logic      gateDrive,
  input wire logic      hvSourceEn,
  input wire logic      csSourceEn,
  input wire logic      standbyMode,
  input wire logic      rampCharge,
  input wire logic      demagComplete
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_dmgOff; gateDrive |-> demagComplete; endproperty
  a_dmgOff: assert property (p_dmgOff) else $error("gate on during demag");
  property p_stOff; hvSourceEn |-> !gateDrive; endproperty
  a_stOff: assert property (p_stOff) else $error("gate on in start-up");
  property p_start; (hvSourceEn && cmpIn.vccAt13)[*3] |-> ##[0:3] !hvSourceEn; endproperty
  a_start: assert property (p_start) else $error("start source stays on");
  property p_stop; (!hvSourceEn && cmpIn.vccAt10)[*4] |=> !gateDrive && !standbyMode; endproperty
  a_stop: assert property (p_stop) else $error("switching past stop level");
  property p_ovp; (!hvSourceEn && cmpIn.vccAbove15v4)[*3] |=> ##1 (!gateDrive)[*8]; endproperty
  a_ovp: assert property (p_ovp) else $error("gate on after supply ovp");
  property p_quick_overvoltage_trip;
    (!hvSourceEn && cmpIn.demagAbove120 && !cmpIn.demagGrounded)[*3] |=> ##1 (!gateDrive)[*8];
  endproperty
  a_quick_overvoltage_trip: assert property (p_quick_overvoltage_trip) else $error("gate on after quick ovp");
  property p_gnd; cmpIn.demagGrounded[*3] |=> demagComplete; endproperty
  a_gnd: assert property (p_gnd) else $error("demag not inhibited");
  property p_hold; $fell(demagComplete) |-> $past(gateDrive); endproperty
  a_hold: assert property (p_hold) else $error("demag fell without pulse");
  property p_self_oscillating_operation; !demagComplete |-> !$rose(rampCharge); endproperty
  a_self_oscillating_operation: assert property (p_self_oscillating_operation) else $error("ramp restarted in demag");
  property p_once; $rose(gateDrive) |-> $rose(rampCharge); endproperty
  a_once: assert property (p_once) else $error("pulse outside cycle start");
  property p_top; cmpIn.rampAtUpper[*3] |=> !rampCharge; endproperty
  a_top: assert property (p_top) else $error("ramp not turned at top");
  property p_csSrc; csSourceEn == (hvSourceEn || standbyMode); endproperty
  a_csSrc: assert property (p_csSrc) else $error("sense source wrong");

  c_pulse: cover property ($rose(gateDrive));
  c_stby: cover property ($rose(standbyMode));
  c_start: cover property ($fell(hvSourceEn));
endmodule : opms_core_sva

bind opms_core opms_core_sva u_sva (.sys_clk, .reset, .cmpIn, .gateDrive, .hvSourceEn,
  .csSourceEn, .standbyMode, .rampCharge, .demagComplete);

`default_nettype wire

// ---- sim/opms_core_tb.sv ----
// self-checking bench for the pwm mode sequencer
`default_nettype none

module opms_core_tb
  import opms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int B24 = 9, BQV = 8, BOV = 7, B13 = 6, B10 = 5, B65 = 4, BGN = 10;
  logic        sys_clk, reset, gateDrive, hvSourceEn, csSourceEn, standbyMode;
  logic        rampCharge, demagComplete, avs_read, avs_write, avs_waitrequest, ocEn;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [7:0]  ctrlLvl, dmgLen;
  opms_cmp_t   knob, cmpIn;
  int          n_fail, comparisons;
  int          cyc = 0;

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  opms_core #(.CNT_W(16)) uut (.sys_clk, .reset, .cmpIn, .gateDrive, .hvSourceEn, .csSourceEn,
    .standbyMode, .rampCharge, .demagComplete, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  opms_front #(.RTOP(20)) far (.sys_clk, .reset, .gateDrive, .rampCharge, .knob, .ocEn,
    .ctrlLvl, .dmgLen, .cmp(cmpIn));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic flag(input int b);
    knob[b] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    knob[b] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : flag

  task automatic edgeOf(input logic lvl, input int lim);
    int n;
    n = 0;
    while (gateDrive !== lvl && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, gateDrive}, {31'h0, lvl});
  endtask : edgeOf

  task automatic pulse;
    edgeOf(1'b0, 300);
    edgeOf(1'b1, 300);
  endtask : pulse

  task automatic quiet(input int cy);
    int hi;
    hi = 0;
    repeat (cy)
    begin
      @(posedge sys_clk);
      hi += int'(gateDrive !== 1'b0);
    end
    chk(32'(hi), 32'h0);
  endtask : quiet

  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rdv & m, e);
  endtask : stat

  task automatic t_regs;
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rdv, 32'h0000_0001);
    stat(32'h0000_0083, 32'h0);
    chk({31'h0, hvSourceEn}, 32'h1);
    bus(1'b1, REG_PULSES, 32'h0000_0005);
    bus(1'b0, REG_PULSES, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(rdv, 32'h0);
  endtask : t_regs

  task automatic t_start;
    flag(B13);
    chk({31'h0, hvSourceEn}, 32'h0);
    stat(32'h3, 32'h1);
    pulse();
    pulse();
    stat(32'h8, 32'h8);
    // run off stops pulses; clear empties the count; period is ramp top plus two sync stages
    bus(1'b1, REG_CTRL, 32'h0);
    quiet(60);
    bus(1'b1, REG_CTRL, 32'h2);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b0, REG_PULSES, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b0, REG_PERIOD, 32'h0);
    chk(rdv, 32'h16);
    bus(1'b1, REG_CTRL, 32'h1);
  endtask : t_start

  task automatic t_duty;
    int on;
    int per;
    ctrlLvl <= 8'hFF;
    pulse();
    pulse();
    on = 0;
    while (gateDrive === 1'b1 && on < 100)
    begin
      @(posedge sys_clk);
      on++;
    end
    per = on;
    while (gateDrive !== 1'b1 && per < 200)
    begin
      @(posedge sys_clk);
      per++;
    end
    chk(32'(on * 5 <= per * 4), 32'h1);
    ctrlLvl <= 8'd10;
  endtask : t_duty

  task automatic t_oc;
    ocEn <= 1'b1;
    pulse();
    pulse();
    stat(32'h8, 32'h0);
    flag(B10);
    stat(32'h7, 32'h2);
    quiet(60);
    flag(B65);
    chk({31'h0, hvSourceEn}, 32'h1);
    ocEn <= 1'b0;
    flag(B13);
    chk({30'h0, standbyMode, csSourceEn}, 32'h0);
  endtask : t_oc

  task automatic t_stby;
    pulse();
    pulse();
    flag(B10);
    stat(32'h7, 32'h6);
    flag(B65);
    stat(32'h7, 32'h4);
    flag(B13);
    chk({30'h0, standbyMode, csSourceEn}, 32'h3);
    pulse();
    pulse();
    flag(B10);
    flag(B65);
    flag(B24);
    flag(B13);
    chk({30'h0, standbyMode, csSourceEn}, 32'h0);
  endtask : t_stby

  task automatic t_ovp;
    for (int k = 0; k < 2; k++)
    begin
      pulse();
      flag(k ? BQV : BOV);
      quiet(60);
      stat(32'h30, k ? 32'h20 : 32'h10);
      flag(B10);
      flag(B65);
      flag(B13);
      pulse();
    end
    knob[BGN] <= 1'b1;
    @(posedge sys_clk);
    flag(BQV);
    stat(32'h20, 32'h0);
    pulse();
    knob[BGN] <= 1'b0;
  endtask : t_ovp

  task automatic t_demag;
    int hi;
    hi = 0;
    dmgLen <= 8'd200;
    pulse();
    edgeOf(1'b0, 300);
    repeat (60) @(posedge sys_clk);
    repeat (90)
    begin
      @(posedge sys_clk);
      hi += int'((gateDrive | rampCharge | demagComplete) !== 1'b0);
    end
    chk(32'(hi), 32'h0);
    pulse();
    dmgLen <= 8'd4;
  endtask : t_demag

  // main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    knob = '0;
    ocEn = 1'b0;
    ctrlLvl = 8'd10;
    dmgLen = 8'd4;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_start();
    t_duty();
    t_oc();
    t_stby();
    t_ovp();
    t_demag();
    report_and_stop();
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
endmodule : opms_core_tb

`default_nettype wire
